// file: src/clock_monitor_alarm_config.sv
// input clock monitor configuration registers and shared alarm pin
// assumes register accesses arrive one per cycle from the serial control port,
// and that the monitor status inputs are already synchronous to clk
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - input-two absent low bit: off/reserved/slow/normal
// - input-one absent low bit, same encoding
// - absent high bits live in preceding register
// - per-input frequency-offset monitor enables
// - monitor-enable register resets to all ones
// - two 8-bit signed output skew registers
// - output-one skew resets to zero
// - reset pin low resets the registers, not the shared pin driver
// - reset pin low restores register defaults
// - clock outputs tristated while reset held
// - shared pin as interrupt, polarity selectable
// - shared pin as input-one alarm
// - alarm level follows alarm polarity bit
// - no function selected: pin high impedance
module clock_monitor_alarm_config
    import clock_monitor_pkg::*;
#(
    parameter int SKEW_WIDTH = 8,
    parameter logic [7:0] OUTPUT_TWO_PHASE_SKEW_RST = 8'h00
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic reset_pin_n,
    input wire reg_req_t reg_req,
    output logic [7:0] reg_rdata_r,
    output logic reg_rvalid_r,
    input wire pin_cfg_t pin_cfg,
    input wire logic irq_level,
    input wire logic input_one_signal_absent_alarm,
    input wire logic input_one_frequency_offset_alarm,
    output absent_mode_t input_one_absent_detect_mode_r,
    output absent_mode_t input_two_absent_detect_mode_r,
    output logic input_one_freq_offset_enable_r,
    output logic input_two_freq_offset_enable_r,
    output logic [SKEW_WIDTH-1:0] output_one_skew_r,
    output logic [SKEW_WIDTH-1:0] output_two_skew_r,
    output logic clock_outputs_enable_r,
    output logic irq_or_input_one_alarm_pin_out_r,
    output logic irq_or_input_one_alarm_pin_oe_r
);

    if (SKEW_WIDTH != 8) begin : g_bad_width
        $error("skew registers are eight bits wide");
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0] monitor_enables_r;
    logic [1:0] absent_high_r;
    logic [7:0] skew_one_r;
    logic [7:0] skew_two_r;
    logic programmed_r;
    logic alarm_level;
    logic write_hit;
    pin_function_t pin_function;

    // the pin reset is taken as a synchronous clear so it shares the clock edge
    // with register writes and cannot glitch the outputs
    logic pin_reset;
    assign pin_reset = !reset_pin_n;
    assign write_hit = reg_req.wr && !pin_reset;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            monitor_enables_r <= INPUT_MONITOR_ENABLES_RST;
        end else if (pin_reset) begin
            monitor_enables_r <= INPUT_MONITOR_ENABLES_RST;
        end else if (reg_req.wr && reg_req.addr == INPUT_MONITOR_ENABLES_OFS) begin
            // reserved bits keep their ones whatever is written
            monitor_enables_r <= reg_req.wdata | MONITOR_RESERVED_MASK;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            absent_high_r <= ABSENT_MODE_HIGH_RST;
        end else if (pin_reset) begin
            absent_high_r <= ABSENT_MODE_HIGH_RST;
        end else if (reg_req.wr && reg_req.addr == ABSENT_MODE_HIGH_OFS) begin
            absent_high_r <= {reg_req.wdata[TWO_ABSENT_HIGH_BIT],
                              reg_req.wdata[ONE_ABSENT_HIGH_BIT]};
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            skew_one_r <= OUTPUT_ONE_PHASE_SKEW_RST;
        end else if (pin_reset) begin
            skew_one_r <= OUTPUT_ONE_PHASE_SKEW_RST;
        end else if (reg_req.wr && reg_req.addr == OUTPUT_ONE_PHASE_SKEW_OFS) begin
            skew_one_r <= reg_req.wdata;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            skew_two_r <= OUTPUT_TWO_PHASE_SKEW_RST;
        end else if (pin_reset) begin
            skew_two_r <= OUTPUT_TWO_PHASE_SKEW_RST;
        end else if (reg_req.wr && reg_req.addr == OUTPUT_TWO_PHASE_SKEW_OFS) begin
            skew_two_r <= reg_req.wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // programmed flag: any write after reset counts as programming
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            programmed_r <= 1'b0;
        end else if (pin_reset) begin
            programmed_r <= 1'b0;
        end else if (write_hit) begin
            programmed_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs to the monitors, skew logic and output stage
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            input_one_absent_detect_mode_r <= ABSENT_NORMAL;
            input_two_absent_detect_mode_r <= ABSENT_NORMAL;
            input_one_freq_offset_enable_r <= 1'b1;
            input_two_freq_offset_enable_r <= 1'b1;
            output_one_skew_r <= '0;
            output_two_skew_r <= '0;
            clock_outputs_enable_r <= 1'b0;
        end else begin
            input_one_absent_detect_mode_r <= absent_mode_t'({absent_high_r[0],
                monitor_enables_r[ONE_ABSENT_LOW_BIT]});
            input_two_absent_detect_mode_r <= absent_mode_t'({absent_high_r[1],
                monitor_enables_r[TWO_ABSENT_LOW_BIT]});
            input_one_freq_offset_enable_r <= monitor_enables_r[ONE_FREQ_BIT];
            input_two_freq_offset_enable_r <= monitor_enables_r[TWO_FREQ_BIT];
            output_one_skew_r <= skew_one_r;
            output_two_skew_r <= skew_two_r;
            // outputs stay off while the reset pin is low and until programmed
            clock_outputs_enable_r <= programmed_r && !pin_reset;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read path: data one cycle after the request
    logic [7:0] read_nxt;

    always_comb begin
        if (reg_req.addr == INPUT_MONITOR_ENABLES_OFS) begin
            read_nxt = monitor_enables_r;
        end else if (reg_req.addr == ABSENT_MODE_HIGH_OFS) begin
            read_nxt = {6'h00, absent_high_r};
        end else if (reg_req.addr == OUTPUT_ONE_PHASE_SKEW_OFS) begin
            read_nxt = skew_one_r;
        end else if (reg_req.addr == OUTPUT_TWO_PHASE_SKEW_OFS) begin
            read_nxt = skew_two_r;
        end else begin
            read_nxt = READ_UNMAPPED;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata_r <= READ_UNMAPPED;
            reg_rvalid_r <= 1'b0;
        end else begin
            reg_rvalid_r <= reg_req.rd && !pin_reset;
            if (reg_req.rd && !pin_reset) begin
                reg_rdata_r <= read_nxt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // input-one alarm: signal absent when monitored, offset when enabled.
    // slow and normal detection both raise the same alarm; the reserved code
    // is treated as off so a stray write cannot raise a false alarm
    always_comb begin
        alarm_level = (absent_active(absent_mode_t'({absent_high_r[0],
                          monitor_enables_r[ONE_ABSENT_LOW_BIT]}))
                       && input_one_signal_absent_alarm)
                      || (monitor_enables_r[ONE_FREQ_BIT]
                       && input_one_frequency_offset_alarm);
    end

    alarm_pin_driver u_pin (
        .clk(clk),
        .rst(rst),
        .cfg(pin_cfg),
        .irq_level(irq_level),
        .alarm_level(alarm_level),
        .pin_out_r(irq_or_input_one_alarm_pin_out_r),
        .pin_oe_r(irq_or_input_one_alarm_pin_oe_r),
        .pin_function_r(pin_function)
    );

    ////////////////////////////////////////////////////////////////////////////
    // checks
    monitor_reset_a: assert property (@(posedge clk) disable iff (rst)
        $past(pin_reset) |-> monitor_enables_r == INPUT_MONITOR_ENABLES_RST
        && skew_one_r == OUTPUT_ONE_PHASE_SKEW_RST && absent_high_r == ABSENT_MODE_HIGH_RST)
        else $error("registers not at default after reset pin");
    reserved_bits_a: assert property (@(posedge clk) disable iff (rst)
        (monitor_enables_r & MONITOR_RESERVED_MASK) == MONITOR_RESERVED_MASK)
        else $error("reserved monitor bits lost their ones");
    skew_write_a: assert property (@(posedge clk) disable iff (rst)
        reg_req.wr && reg_req.addr == OUTPUT_TWO_PHASE_SKEW_OFS && reset_pin_n
        |=> ##1 output_two_skew_r == $past(reg_req.wdata, 2))
        else $error("output two skew did not follow write");
    mode_split_a: assert property (@(posedge clk) disable iff (rst)
        input_one_absent_detect_mode_r == {$past(absent_high_r[0]),
        $past(monitor_enables_r[ONE_ABSENT_LOW_BIT])})
        else $error("input one absent mode not formed from both registers");
    freq_enable_a: assert property (@(posedge clk) disable iff (rst)
        input_two_freq_offset_enable_r == $past(monitor_enables_r[TWO_FREQ_BIT]))
        else $error("input two offset enable wrong");
    outputs_off_a: assert property (@(posedge clk) disable iff (rst)
        pin_reset |=> !clock_outputs_enable_r [*2])
        else $error("clock outputs enabled during reset");
    unprogrammed_a: assert property (@(posedge clk) disable iff (rst)
        !programmed_r |=> !clock_outputs_enable_r)
        else $error("clock outputs enabled before programming");
    alarm_select_a: assert property (@(posedge clk) disable iff (rst)
        $past(pin_cfg.input_one_alarm_pin_select) && !$past(pin_cfg.irq_pin_select)
        |-> pin_function == PIN_ALARM)
        else $error("alarm function not selected");
    // no accepted write since the last reset means the register still holds its default
    read_latency_a: assert property (@(posedge clk) disable iff (rst)
        reg_req.rd && reset_pin_n && reg_req.addr == INPUT_MONITOR_ENABLES_OFS
        && !programmed_r |=> reg_rvalid_r && reg_rdata_r == INPUT_MONITOR_ENABLES_RST)
        else $error("monitor enables not all ones after reset");

endmodule : clock_monitor_alarm_config

// file: src/clock_monitor_pkg.sv
// package for the clock monitor configuration and alarm pin logic
// assumes one 200 MHz clock and byte-wide register accesses from the serial control port
package clock_monitor_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [7:0] ABSENT_MODE_HIGH_OFS = 8'h8A;
    localparam logic [7:0] INPUT_MONITOR_ENABLES_OFS = 8'h8B;
    localparam logic [7:0] OUTPUT_ONE_PHASE_SKEW_OFS = 8'h8E;
    localparam logic [7:0] OUTPUT_TWO_PHASE_SKEW_OFS = 8'h8F;

    ////////////////////////////////////////////////////////////////////////////
    // field positions inside the monitor-enable register
    localparam int TWO_ABSENT_LOW_BIT = 5;
    localparam int ONE_ABSENT_LOW_BIT = 4;
    localparam int TWO_FREQ_BIT = 1;
    localparam int ONE_FREQ_BIT = 0;
    // field positions inside the preceding register
    localparam int TWO_ABSENT_HIGH_BIT = 1;
    localparam int ONE_ABSENT_HIGH_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [7:0] INPUT_MONITOR_ENABLES_RST = 8'hFF;
    localparam logic [7:0] OUTPUT_ONE_PHASE_SKEW_RST = 8'h00;
    localparam logic [1:0] ABSENT_MODE_HIGH_RST = 2'h3;
    // reserved bits of the monitor-enable register are fixed at their reset ones
    localparam logic [7:0] MONITOR_RESERVED_MASK = 8'hCC;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // signal-absent detection codes
    typedef enum logic [1:0] {
        ABSENT_OFF = 2'h0,
        ABSENT_RESERVED = 2'h1,
        ABSENT_SLOW = 2'h2,
        ABSENT_NORMAL = 2'h3
    } absent_mode_t;

    // function of the shared interrupt / alarm pin
    typedef enum logic [1:0] {
        PIN_HIGH_Z,
        PIN_IRQ,
        PIN_ALARM
    } pin_function_t;

    // one access from the serial control port
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // pin configuration bits
    typedef struct packed {
        logic irq_pin_select;
        logic irq_polarity;
        logic input_one_alarm_pin_select;
        logic alarm_pin_polarity;
    } pin_cfg_t;

    function automatic logic absent_active(input absent_mode_t mode);
        absent_active = (mode == ABSENT_SLOW) || (mode == ABSENT_NORMAL);
    endfunction : absent_active

endpackage : clock_monitor_pkg

// file: src/alarm_pin_driver.sv
// shared interrupt / input-one alarm pin driver
// assumes the alarm and interrupt levels are synchronous to clk
`timescale 1ns/10ps
module alarm_pin_driver
    import clock_monitor_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire pin_cfg_t cfg,
    input wire logic irq_level,
    input wire logic alarm_level,
    output logic pin_out_r,
    output logic pin_oe_r,
    output pin_function_t pin_function_r
);

    pin_function_t func_nxt;
    logic out_nxt;

    always_comb begin
        func_nxt = PIN_HIGH_Z;
        out_nxt = 1'b0;
        if (cfg.irq_pin_select) begin
            func_nxt = PIN_IRQ;
            out_nxt = irq_level ~^ cfg.irq_polarity;
        end else if (cfg.input_one_alarm_pin_select) begin
            func_nxt = PIN_ALARM;
            out_nxt = alarm_level ~^ cfg.alarm_pin_polarity;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_out_r <= 1'b0;
            pin_oe_r <= 1'b0;
            pin_function_r <= PIN_HIGH_Z;
        end else begin
            pin_out_r <= out_nxt;
            pin_oe_r <= (func_nxt != PIN_HIGH_Z);
            pin_function_r <= func_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    pin_tristate_a: assert property (@(posedge clk) disable iff (rst)
        !$past(cfg.irq_pin_select) && !$past(cfg.input_one_alarm_pin_select) |-> !pin_oe_r)
        else $error("shared pin driven with no function selected");
    irq_level_a: assert property (@(posedge clk) disable iff (rst)
        $past(cfg.irq_pin_select) |-> pin_oe_r &&
        pin_out_r == ($past(irq_level) ~^ $past(cfg.irq_polarity)))
        else $error("interrupt level on shared pin wrong");
    alarm_level_a: assert property (@(posedge clk) disable iff (rst)
        !$past(cfg.irq_pin_select) && $past(cfg.input_one_alarm_pin_select) |->
        pin_oe_r && pin_out_r == ($past(alarm_level) ~^ $past(cfg.alarm_pin_polarity)))
        else $error("alarm level on shared pin wrong");

endmodule : alarm_pin_driver

// file: verification/host_model.sv
// host model: byte reads and writes on the register request port
// assumes the device answers a read with a one-cycle valid pulse
`timescale 1ns/10ps
module host_model
    import clock_monitor_pkg::*;
(
    input wire logic clk,
    output reg_req_t reg_req,
    input wire logic [7:0] reg_rdata_r,
    input wire logic reg_rvalid_r
);
    initial reg_req = '0;

    // the host programs before it expects any clock output
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req <= '0;
    endtask : write_reg

    // bounded wait: a lost answer is reported, never hangs
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic ok);
        int n;
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        reg_req <= '0;
        n = 0;
        #1;
        while (reg_rvalid_r !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        ok = (reg_rvalid_r === 1'b1);
        d = reg_rdata_r;
    endtask : read_reg
endmodule : host_model

// file: verification/clock_monitor_alarm_config_tb.sv
// testbench for the monitor configuration registers and shared alarm pin
// assumes host_model drives the register port; pin inputs driven here
`timescale 1ns/10ps
module clock_monitor_alarm_config_tb
    import clock_monitor_pkg::*;
();
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reset_pin_n = 1'b1;
    reg_req_t reg_req;
    pin_cfg_t pin_cfg = '0;
    logic irq_level = 1'b0;
    logic absent_alarm = 1'b0;
    logic offset_alarm = 1'b0;
    absent_mode_t mode_one, mode_two;
    logic [7:0] reg_rdata_r, skew_one, skew_two, rd;
    logic reg_rvalid_r, fen_one, fen_two, clk_oe, pin_out, pin_oe, ok, exp_oe, lvl, pol;
    logic [1:0] code, inv;
    int err_total = 0;
    int comparisons = 0;

    always #2.5 clk = ~clk;

    host_model i_host_model (.clk(clk), .reg_req(reg_req), .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r));

    clock_monitor_alarm_config #(.SKEW_WIDTH(8), .OUTPUT_TWO_PHASE_SKEW_RST(8'h00))
    i_clock_monitor_alarm_config (
        .clk(clk),
        .rst(rst),
        .reset_pin_n(reset_pin_n),
        .reg_req(reg_req),
        .reg_rdata_r(reg_rdata_r),
        .reg_rvalid_r(reg_rvalid_r),
        .pin_cfg(pin_cfg),
        .irq_level(irq_level),
        .input_one_signal_absent_alarm(absent_alarm),
        .input_one_frequency_offset_alarm(offset_alarm),
        .input_one_absent_detect_mode_r(mode_one),
        .input_two_absent_detect_mode_r(mode_two),
        .input_one_freq_offset_enable_r(fen_one),
        .input_two_freq_offset_enable_r(fen_two),
        .output_one_skew_r(skew_one),
        .output_two_skew_r(skew_two),
        .clock_outputs_enable_r(clk_oe),
        .irq_or_input_one_alarm_pin_out_r(pin_out),
        .irq_or_input_one_alarm_pin_oe_r(pin_oe)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic print_verdict();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check_read(input logic [7:0] a, input logic [7:0] exp);
        i_host_model.read_reg(a, rd, ok);
        if (ok !== 1'b1) begin
            err_total++;
            $display("MISMATCH t=%0t no read answer addr=%h exp=%h", $time, a, exp);
            print_verdict();
        end else begin
            chk_byte(rd, exp);
        end
    endtask : check_read

    // registers land on one edge, ports one edge later
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask : settle

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        settle();
        chk_bit(clk_oe, 1'b0);
        chk_byte({4'h0, mode_two, mode_one}, 8'h0F);
        chk_byte({6'h00, fen_two, fen_one}, 8'h03);
        check_read(INPUT_MONITOR_ENABLES_OFS, 8'hFF);
        check_read(OUTPUT_ONE_PHASE_SKEW_OFS, 8'h00);
        check_read(8'h10, READ_UNMAPPED);
        $display("test defaults done");
        // input two gets the inverse code so swapped fields cannot pass
        for (int c = 0; c < 4; c++) begin
            code = c[1:0];
            inv = ~code;
            i_host_model.write_reg(ABSENT_MODE_HIGH_OFS, {6'h00, inv[1], code[1]});
            i_host_model.write_reg(INPUT_MONITOR_ENABLES_OFS,
                {2'b00, inv[0], code[0], 2'b00, inv[0], code[0]});
            pin_cfg <= 4'b0011;
            absent_alarm <= 1'b1;
            offset_alarm <= 1'b0;
            settle();
            chk_byte({6'h00, mode_one}, {6'h00, code});
            chk_byte({6'h00, mode_two}, {6'h00, inv});
            chk_byte({6'h00, fen_two, fen_one}, {6'h00, inv[0], code[0]});
            chk_bit(pin_out, code[1]);
            @(posedge clk);
            absent_alarm <= 1'b0;
            offset_alarm <= 1'b1;
            settle();
            chk_bit(pin_out, code[0]);
            check_read(INPUT_MONITOR_ENABLES_OFS,
                {2'b11, inv[0], code[0], 2'b11, inv[0], code[0]});
        end
        chk_bit(clk_oe, 1'b1);
        $display("test monitor modes done");
        i_host_model.write_reg(OUTPUT_ONE_PHASE_SKEW_OFS, 8'h80);
        i_host_model.write_reg(OUTPUT_TWO_PHASE_SKEW_OFS, 8'h7F);
        settle();
        chk_byte(skew_one, 8'h80);
        chk_byte(skew_two, 8'h7F);
        check_read(OUTPUT_TWO_PHASE_SKEW_OFS, 8'h7F);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        // taken while the pin is low, so it must leave no trace
        i_host_model.write_reg(OUTPUT_TWO_PHASE_SKEW_OFS, 8'h11);
        settle();
        chk_bit(clk_oe, 1'b0);
        chk_byte(skew_one, 8'h00);
        chk_byte({4'h0, mode_two, mode_one}, 8'h0F);
        // a read while the pin is low must get no answer
        i_host_model.read_reg(OUTPUT_ONE_PHASE_SKEW_OFS, rd, ok);
        chk_bit(ok, 1'b0);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        check_read(OUTPUT_TWO_PHASE_SKEW_OFS, 8'h00);
        check_read(INPUT_MONITOR_ENABLES_OFS, 8'hFF);
        chk_bit(clk_oe, 1'b0);
        $display("test skew and reset pin done");
        // irq and alarm levels are opposite so the chosen source shows
        for (int i = 0; i < 32; i++) begin
            @(posedge clk);
            pin_cfg <= i[3:0];
            irq_level <= i[4];
            absent_alarm <= ~i[4];
            offset_alarm <= 1'b0;
            settle();
            exp_oe = i[3] | i[1];
            lvl = i[3] ? i[4] : ~i[4];
            pol = i[3] ? i[2] : i[0];
            chk_bit(pin_oe, exp_oe);
            chk_bit(pin_out, exp_oe ? ~(lvl ^ pol) : 1'b0);
        end
        $display("test shared pin done");
        print_verdict();
    end
endmodule : clock_monitor_alarm_config_tb
